// ===== hdl/xb_core.sv
/*
 Crossbar switch core: per-port ingress and egress frame buffers joined by
 a 12x12 crossbar, plus the FIFO they are built from.
 Assumes port logic routes packets and gives each a descriptor, keeps the
 queue type steady within a packet, and reports acknowledged bytes.
*/
`timescale 1ns/1ps

// ----------------------------------------
// Plain FIFO with valid and ready on both sides
// ----------------------------------------
module xb_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic wr_valid_in,
	input wire logic [W-1:0] wr_data_in,
	output logic wr_ready_out,
	output logic rd_valid_out,
	output logic [W-1:0] rd_data_out,
	input wire logic rd_ready_in,
	output logic [$clog2(D):0] count_out
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} xb_fifo_s;
	xb_fifo_s r_reg;
	xb_fifo_s r_next;
	logic push;
	logic pop;

	// Depth must be a power of two so pointers wrap on their own
	always_comb begin
		r_next = r_reg;
		push = wr_valid_in && (r_reg.cnt != (AW+1)'(D));
		pop = rd_ready_in && (r_reg.cnt != '0);
		if (push) begin
			r_next.mem[r_reg.wp] = wr_data_in;
			r_next.wp = r_reg.wp + 1'b1;
		end
		if (pop) begin
			r_next.rp = r_reg.rp + 1'b1;
		end
		r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign wr_ready_out = r_reg.cnt != (AW+1)'(D);
	assign rd_valid_out = r_reg.cnt != '0;
	assign rd_data_out = r_reg.mem[r_reg.rp];
	assign count_out = r_reg.cnt;
endmodule

// ----------------------------------------
// Switch core top
// ----------------------------------------
module xb_core (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [5:0] merge_in,
	input wire logic [11:0] ing_valid_in,
	input wire logic [11:0] ing_sop_in,
	input wire logic [11:0] ing_eop_in,
	input wire logic [11:0][159:0] ing_data_in,
	input wire logic [11:0][3:0] ing_dest_in,
	input wire logic [11:0][1:0] ing_qtype_in,
	input wire logic [11:0][2:0] ing_tc_in,
	input wire logic [11:0][13:0] ing_len_in,
	output logic [11:0][2:0] ing_ready_out,
	input wire logic [11:0][7:0] tc_vc_map_in,
	output logic [11:0] eg_valid_out,
	output logic [11:0] eg_sop_out,
	output logic [11:0] eg_eop_out,
	output logic [11:0][159:0] eg_data_out,
	output logic [11:0][1:0] eg_qtype_out,
	output logic [11:0] eg_vc_out,
	input wire logic [11:0] eg_rd_in,
	input wire logic [11:0] ack_in,
	input wire logic [11:0][1:0] ack_qtype_in,
	input wire logic [11:0][13:0] ack_len_in,
	output logic [11:0] port_visible_out,
	output logic [11:0][2:0][9:0] adv_data_credit_out,
	output logic [11:0][7:0] adv_hdr_credit_out
);
	localparam int N = xb_pkg::NPORT;
	localparam int NQ = xb_pkg::NQ;
	localparam int BW = xb_pkg::BW;
	localparam int CW = xb_pkg::CW;
	localparam int RW = xb_pkg::RW;
	localparam int WW = $bits(xb_pkg::xb_word_s);
	localparam int IDW = $bits(xb_pkg::xb_in_desc_s);
	localparam int EDW = $bits(xb_pkg::xb_eg_desc_s);
	localparam int FCW = $clog2(xb_pkg::FDEPTH) + 1;

	typedef struct packed {
		logic [N-1:0][NQ-1:0] in_rdy;
		logic [N-1:0] in_mid;
		logic [N-1:0][NQ-1:0][BW-1:0] in_bytes;
		logic [N-1:0][NQ-1:0][CW-1:0] in_pkts;
		logic [N-1:0][NQ-1:0][BW-1:0] eg_bytes;
		logic [N-1:0][NQ-1:0][CW-1:0] eg_pkts;
		logic [N-1:0][RW-1:0] replay;
		xb_pkg::xb_lane_e [N-1:0] lane;
		logic [N-1:0][xb_pkg::PW-1:0] src;
		logic [N-1:0] src_busy;
		logic [N-1:0] out_valid;
		logic [N-1:0] out_sop;
		logic [N-1:0] out_eop;
		logic [N-1:0][xb_pkg::DW-1:0] out_data;
		logic [N-1:0][1:0] out_q;
		logic [N-1:0] out_vc;
		logic [N-1:0] visible;
		logic [N-1:0][NQ-1:0][xb_pkg::DCW-1:0] dcred;
		logic [N-1:0][xb_pkg::HCW-1:0] hcred;
	} xb_state_s;
	xb_state_s r_reg;
	xb_state_s r_next;

	// FIFO handshake wires, one set per port
	xb_pkg::xb_word_s ixw_d [N];
	xb_pkg::xb_word_s ixr_d [N];
	xb_pkg::xb_word_s exw_d [N];
	xb_pkg::xb_word_s exr_d [N];
	xb_pkg::xb_in_desc_s idw_d [N];
	xb_pkg::xb_in_desc_s idr_d [N];
	xb_pkg::xb_eg_desc_s edw_d [N];
	xb_pkg::xb_eg_desc_s edr_d [N];
	logic [N-1:0] ixw_v, ixr_v, ixpop, exw_v, exw_r, exr_v, expop;
	logic [N-1:0] idw_v, idr_v, idpop, edw_v, edw_r, edr_v, edpop;
	logic [FCW-1:0] ixcnt [N];
	logic [FCW-1:0] idcnt [N];

	// Limits selected by port mode
	function automatic logic [BW-1:0] f_bytes(input logic [1:0] q, input logic x8);
		if (q == xb_pkg::Q_NONPOSTED) begin
			f_bytes = x8 ? xb_pkg::X8_NP_BYTES : xb_pkg::X4_NP_BYTES;
		end else begin
			f_bytes = x8 ? xb_pkg::X8_PC_BYTES : xb_pkg::X4_PC_BYTES;
		end
	endfunction

	// ----------------------------------------
	// Per-port frame buffers
	// ----------------------------------------
	// Descriptor and data memories are kept apart in both buffers of a port, which all queues share
	generate
		for (genvar p = 0; p < N; p++) begin : g_port
			xb_fifo #(.W(WW), .D(xb_pkg::FDEPTH)) u_in_data (
				.clk_in(clk_in), .rst_in(rst_in),
				.wr_valid_in(ixw_v[p]), .wr_data_in(ixw_d[p]), .wr_ready_out(),
				.rd_valid_out(ixr_v[p]), .rd_data_out(ixr_d[p]),
				.rd_ready_in(ixpop[p]), .count_out(ixcnt[p])
			);
			xb_fifo #(.W(IDW), .D(xb_pkg::FDEPTH)) u_in_desc (
				.clk_in(clk_in), .rst_in(rst_in),
				.wr_valid_in(idw_v[p]), .wr_data_in(idw_d[p]), .wr_ready_out(),
				.rd_valid_out(idr_v[p]), .rd_data_out(idr_d[p]),
				.rd_ready_in(idpop[p]), .count_out(idcnt[p])
			);
			xb_fifo #(.W(WW), .D(xb_pkg::FDEPTH)) u_eg_data (
				.clk_in(clk_in), .rst_in(rst_in),
				.wr_valid_in(exw_v[p]), .wr_data_in(exw_d[p]), .wr_ready_out(exw_r[p]),
				.rd_valid_out(exr_v[p]), .rd_data_out(exr_d[p]),
				.rd_ready_in(expop[p]), .count_out()
			);
			xb_fifo #(.W(EDW), .D(xb_pkg::FDEPTH)) u_eg_desc (
				.clk_in(clk_in), .rst_in(rst_in),
				.wr_valid_in(edw_v[p]), .wr_data_in(edw_d[p]), .wr_ready_out(edw_r[p]),
				.rd_valid_out(edr_v[p]), .rd_data_out(edr_d[p]),
				.rd_ready_in(edpop[p]), .count_out()
			);
		end
	endgenerate

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	// One pass: ingress accept, crossbar lanes, egress output, accounting
	always_comb begin
		logic [N-1:0] taken;
		logic acc;
		logic x8;
		logic hid;
		logic g;
		logic [1:0] q;
		logic [xb_pkg::PW-1:0] s;
		logic [BW:0] need;
		r_next = r_reg;
		taken = r_reg.src_busy;
		acc = 1'b0;
		x8 = 1'b0;
		hid = 1'b0;
		g = 1'b0;
		q = '0;
		s = '0;
		need = '0;
		ixw_v = '0;
		idw_v = '0;
		ixpop = '0;
		idpop = '0;
		exw_v = '0;
		edw_v = '0;
		expop = '0;
		edpop = '0;
		for (int p = 0; p < N; p++) begin
			ixw_d[p] = '0;
			idw_d[p] = '0;
			exw_d[p] = '0;
			edw_d[p] = '0;
		end
		// Ingress: accept words into the queue named by the packet type
		for (int i = 0; i < N; i++) begin
			q = ing_qtype_in[i];
			acc = ing_valid_in[i] && (q < 2'(NQ)) && r_reg.in_rdy[i][q];
			ixw_v[i] = acc;
			ixw_d[i] = '{sop: ing_sop_in[i], eop: ing_eop_in[i], data: ing_data_in[i]};
			idw_v[i] = acc && ing_sop_in[i];
			idw_d[i] = '{dest: ing_dest_in[i], q: q, tc: ing_tc_in[i], len: ing_len_in[i]};
			if (acc && ing_sop_in[i]) begin
				r_next.in_bytes[i][q] = r_next.in_bytes[i][q] + ing_len_in[i];
				r_next.in_pkts[i][q] = r_next.in_pkts[i][q] + 1'b1;
			end
			if (acc) begin
				r_next.in_mid[i] = !ing_eop_in[i];
			end
		end
		// Crossbar: each egress lane locks one source for a whole packet
		for (int e = 0; e < N; e++) begin
			x8 = merge_in[e >> 1] && (e % 2 == 0);
			g = 1'b0;
			case (r_reg.lane[e])
				xb_pkg::LANE_IDLE: begin
					for (int i = 0; i < N; i++) begin
						q = idr_d[i].q;
						need = {1'b0, r_reg.eg_bytes[e][q]} + {1'b0, idr_d[i].len};
						// Egress link credits are not looked at here
						if (!g && !taken[i] && idr_v[i] && idr_d[i].dest == 4'(e)
							&& r_reg.visible[e] && edw_r[e]
							&& r_reg.eg_pkts[e][q] < (x8 ? xb_pkg::X8_EG_PKTS : xb_pkg::X4_PKTS)
							&& need <= {1'b0, f_bytes(q, x8)}) begin
							g = 1'b1;
							taken[i] = 1'b1;
							r_next.src_busy[i] = 1'b1;
							r_next.src[e] = 4'(i);
							r_next.lane[e] = xb_pkg::LANE_MOVE;
							edw_v[e] = 1'b1;
							edw_d[e] = '{q: q, vc: tc_vc_map_in[e][idr_d[i].tc],
								len: idr_d[i].len};
							r_next.eg_bytes[e][q] = r_next.eg_bytes[e][q] + idr_d[i].len;
							r_next.eg_pkts[e][q] = r_next.eg_pkts[e][q] + 1'b1;
						end
					end
				end
				xb_pkg::LANE_MOVE: begin
					s = r_reg.src[e];
					if (ixr_v[s] && exw_r[e]) begin
						ixpop[s] = 1'b1;
						exw_v[e] = 1'b1;
						exw_d[e] = ixr_d[s];
						if (ixr_d[s].eop) begin
							q = idr_d[s].q;
							idpop[s] = 1'b1;
							r_next.in_bytes[s][q] = r_next.in_bytes[s][q] - idr_d[s].len;
							r_next.in_pkts[s][q] = r_next.in_pkts[s][q] - 1'b1;
							r_next.src_busy[s] = 1'b0;
							r_next.lane[e] = xb_pkg::LANE_IDLE;
						end
					end
				end
				default: begin
					r_next.lane[e] = xb_pkg::LANE_IDLE;
				end
			endcase
		end
		// Egress: link layer pulls words; sent packets sit in replay space
		for (int e = 0; e < N; e++) begin
			x8 = merge_in[e >> 1] && (e % 2 == 0);
			if (r_reg.out_valid[e] && eg_rd_in[e] && r_reg.out_eop[e]) begin
				r_next.replay[e] = r_next.replay[e] + 1'b1;
			end
			if (!r_reg.out_valid[e] || eg_rd_in[e]) begin
				// Count an eop read this cycle too, or one packet slips past the cap
				acc = exr_v[e] && edr_v[e] && (!exr_d[e].sop
					|| r_next.replay[e] < (x8 ? xb_pkg::X8_REPLAY : xb_pkg::X4_REPLAY));
				r_next.out_valid[e] = acc;
				if (acc) begin
					expop[e] = 1'b1;
					edpop[e] = exr_d[e].eop;
					r_next.out_sop[e] = exr_d[e].sop;
					r_next.out_eop[e] = exr_d[e].eop;
					r_next.out_data[e] = exr_d[e].data;
					r_next.out_q[e] = edr_d[e].q;
					r_next.out_vc[e] = edr_d[e].vc;
				end
			end
			// Space returns to egress queuing only on acknowledge
			if (ack_in[e] && ack_qtype_in[e] < 2'(NQ)) begin
				if (r_reg.replay[e] != '0) begin
					r_next.replay[e] = r_next.replay[e] - 1'b1;
				end
				r_next.eg_bytes[e][ack_qtype_in[e]] =
					r_next.eg_bytes[e][ack_qtype_in[e]] - ack_len_in[e];
				r_next.eg_pkts[e][ack_qtype_in[e]] = r_next.eg_pkts[e][ack_qtype_in[e]] - 1'b1;
			end
		end
		// Mode, visibility, credits and registered ready per queue
		for (int i = 0; i < N; i++) begin
			x8 = merge_in[i >> 1] && (i % 2 == 0);
			hid = merge_in[i >> 1] && (i % 2 == 1);
			r_next.visible[i] = !hid;
			r_next.hcred[i] = x8 ? xb_pkg::X8_HCRED : xb_pkg::X4_HCRED;
			for (int k = 0; k < NQ; k++) begin
				q = 2'(k);
				if (q == xb_pkg::Q_NONPOSTED) begin
					r_next.dcred[i][k] = x8 ? xb_pkg::X8_NP_DCRED : xb_pkg::X4_NP_DCRED;
				end else begin
					r_next.dcred[i][k] = x8 ? xb_pkg::X8_PC_DCRED : xb_pkg::X4_PC_DCRED;
				end
				// Ready is one cycle late, so the FIFOs keep two slots spare
				acc = r_next.in_pkts[i][k] < (x8 ? xb_pkg::X8_IN_PKTS : xb_pkg::X4_PKTS)
					&& r_next.in_bytes[i][k] <= f_bytes(q, x8) - xb_pkg::MAX_TLP_BYTES;
				r_next.in_rdy[i][k] = !hid && ixcnt[i] <= xb_pkg::FIFO_ROOM
					&& idcnt[i] <= xb_pkg::FIFO_ROOM && (r_next.in_mid[i] || acc);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs, all from state flops
	// ----------------------------------------
	assign ing_ready_out = r_reg.in_rdy;
	assign eg_valid_out = r_reg.out_valid;
	assign eg_sop_out = r_reg.out_sop;
	assign eg_eop_out = r_reg.out_eop;
	assign eg_data_out = r_reg.out_data;
	assign eg_qtype_out = r_reg.out_q;
	assign eg_vc_out = r_reg.out_vc;
	assign port_visible_out = r_reg.visible;
	assign adv_data_credit_out = r_reg.dcred;
	assign adv_hdr_credit_out = r_reg.hcred;
endmodule

// ===== hdl/xb_pkg.sv
/*
 Shared constants and types of the crossbar switch core.
 Assumes nothing of its surroundings.
*/
package xb_pkg;
	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NPORT = 12;
	localparam int NQ = 3;
	localparam int DW = 160;
	localparam int PW = 4;
	localparam int BW = 14;
	localparam int CW = 8;
	localparam int RW = 7;
	localparam int DCW = 10;
	localparam int HCW = 8;
	localparam int TCW = 3;
	localparam int FDEPTH = 8;
	localparam logic [3:0] FIFO_ROOM = 4'h6;
	// ----------------------------------------
	// Queue types
	// ----------------------------------------
	localparam logic [1:0] Q_POSTED = 2'h0;
	localparam logic [1:0] Q_NONPOSTED = 2'h1;
	localparam logic [1:0] Q_COMPLETION = 2'h2;
	// ----------------------------------------
	// Queue limits and advertised credits
	// ----------------------------------------
	localparam logic [BW-1:0] X4_PC_BYTES = 14'h1820;
	localparam logic [BW-1:0] X4_NP_BYTES = 14'h0400;
	localparam logic [BW-1:0] X8_PC_BYTES = 14'h3040;
	localparam logic [BW-1:0] X8_NP_BYTES = 14'h0800;
	localparam logic [BW-1:0] MAX_TLP_BYTES = 14'h0200;
	localparam logic [CW-1:0] X4_PKTS = 8'h40;
	localparam logic [CW-1:0] X8_IN_PKTS = 8'h7f;
	localparam logic [CW-1:0] X8_EG_PKTS = 8'h80;
	localparam logic [RW-1:0] X4_REPLAY = 7'h20;
	localparam logic [RW-1:0] X8_REPLAY = 7'h40;
	localparam logic [DCW-1:0] X4_PC_DCRED = 10'h182;
	localparam logic [DCW-1:0] X4_NP_DCRED = 10'h040;
	localparam logic [DCW-1:0] X8_PC_DCRED = 10'h304;
	localparam logic [DCW-1:0] X8_NP_DCRED = 10'h080;
	localparam logic [HCW-1:0] X4_HCRED = 8'h40;
	localparam logic [HCW-1:0] X8_HCRED = 8'h7f;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic {LANE_IDLE = 1'b0, LANE_MOVE = 1'b1} xb_lane_e;
	typedef struct packed {
		logic sop;
		logic eop;
		logic [DW-1:0] data;
	} xb_word_s;
	typedef struct packed {
		logic [PW-1:0] dest;
		logic [1:0] q;
		logic [TCW-1:0] tc;
		logic [BW-1:0] len;
	} xb_in_desc_s;
	typedef struct packed {
		logic [1:0] q;
		logic vc;
		logic [BW-1:0] len;
	} xb_eg_desc_s;
endpackage

// ===== tb/xb_core_props.sv
/*
 Port checker of the switch core.
 Assumes a bind to xb_core and acks that never outrun sent packets.
*/
`timescale 1ns/1ps
module xb_core_props (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [5:0] merge_in,
	input wire logic [11:0][2:0] ing_ready_out,
	input wire logic [11:0] eg_valid_out,
	input wire logic [11:0] eg_sop_out,
	input wire logic [11:0] eg_eop_out,
	input wire logic [11:0][159:0] eg_data_out,
	input wire logic [11:0][1:0] eg_qtype_out,
	input wire logic [11:0] eg_rd_in,
	input wire logic [11:0] ack_in,
	input wire logic [11:0] port_visible_out,
	input wire logic [11:0][2:0][9:0] adv_data_credit_out,
	input wire logic [11:0][7:0] adv_hdr_credit_out
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic [11:0] tk;
	logic [11:0] open_reg;
	logic [7:0] replay_reg;
	assign tk = eg_valid_out & eg_rd_in;
	// Open packets per port; unacked packets of port 0 seen on the wire
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			open_reg <= 12'h000;
			replay_reg <= 8'h00;
		end else begin
			open_reg <= (open_reg | (tk & eg_sop_out)) & ~(tk & eg_eop_out);
			replay_reg <= replay_reg + 8'(tk[0] & eg_eop_out[0]) - 8'(ack_in[0]);
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// A sop must wait for acks once the store is full
	replay_cap_a: assert property (replay_reg <= (merge_in[0] ? 8'h40 : 8'h20))
		else $error("replay store over cap");
	for (genvar p = 0; p < 12; p++) begin : g_port
		eg_stand_a: assert property (eg_valid_out[p] && !eg_rd_in[p] |=> eg_valid_out[p]
			&& $stable(eg_data_out[p]) && $stable(eg_qtype_out[p]) && $stable(eg_sop_out[p]))
			else $error("egress word moved before read");
		no_interleave_a: assert property (open_reg[p] && eg_valid_out[p] |-> !eg_sop_out[p])
			else $error("packet interleaved");
	end
	// Credits are registered, so the mode must have held one cycle
	for (genvar k = 0; k < 6; k++) begin : g_pair
		odd_hidden_a: assert property (merge_in[k] && $past(merge_in[k]) |->
			!port_visible_out[2*k+1] && ing_ready_out[2*k+1] == 3'h0 && !eg_valid_out[2*k+1])
			else $error("merged odd port active");
		even_shown_a: assert property ($past(merge_in[k]) && !$past(rst_in) |->
			port_visible_out[2*k]) else $error("merged even port hidden");
		x4_pc_credit_a: assert property (!$past(merge_in[k]) && !$past(rst_in) |->
			adv_hdr_credit_out[2*k] == xb_pkg::X4_HCRED
			&& adv_data_credit_out[2*k][0] == xb_pkg::X4_PC_DCRED
			&& adv_data_credit_out[2*k][2] == xb_pkg::X4_PC_DCRED) else $error("x4 credits");
		x4_np_credit_a: assert property (!$past(merge_in[k]) && !$past(rst_in) |->
			adv_data_credit_out[2*k+1][1] == xb_pkg::X4_NP_DCRED) else $error("x4 np credits");
		x8_credit_a: assert property ($past(merge_in[k]) && !$past(rst_in) |->
			adv_hdr_credit_out[2*k] == xb_pkg::X8_HCRED
			&& adv_data_credit_out[2*k] == {xb_pkg::X8_PC_DCRED, xb_pkg::X8_NP_DCRED,
			xb_pkg::X8_PC_DCRED}) else $error("x8 credits");
	end
endmodule
bind xb_core xb_core_props u_props (.clk_in, .rst_in, .merge_in, .ing_ready_out, .eg_valid_out,
	.eg_sop_out, .eg_eop_out, .eg_data_out, .eg_qtype_out, .eg_rd_in, .ack_in,
	.port_visible_out, .adv_data_credit_out, .adv_hdr_credit_out);

// ===== tb/xb_core_tb.sv
/*
 Self-checking bench of the switch core with random packet traffic.
 Assumes the link model answers every egress port.
*/
`timescale 1ns/1ps
module xb_core_tb;
	logic clk_in, rst_in;
	logic [5:0] merge_in;
	logic [11:0] ing_valid_in, ing_sop_in, ing_eop_in, eg_valid_out, eg_sop_out, eg_eop_out;
	logic [11:0][159:0] ing_data_in, eg_data_out;
	logic [11:0][3:0] ing_dest_in;
	logic [11:0][1:0] ing_qtype_in, eg_qtype_out, ack_qtype_in;
	logic [11:0][2:0] ing_tc_in, ing_ready_out;
	logic [11:0][13:0] ing_len_in, ack_len_in;
	logic [11:0][7:0] tc_vc_map_in, adv_hdr_credit_out;
	logic [11:0] eg_vc_out, eg_rd_in, ack_in, port_visible_out, hold, ack_en;
	logic [11:0][2:0][9:0] adv_data_credit_out;
	logic [164:0] expq [144][$];
	logic [31:0] seed = 32'h0000_005d;
	int error_cnt, n_compared, idx, deliv [12];

	xb_core dut (.clk_in, .rst_in, .merge_in, .ing_valid_in, .ing_sop_in, .ing_eop_in,
		.ing_data_in, .ing_dest_in, .ing_qtype_in, .ing_tc_in, .ing_len_in, .ing_ready_out,
		.tc_vc_map_in, .eg_valid_out, .eg_sop_out, .eg_eop_out, .eg_data_out, .eg_qtype_out,
		.eg_vc_out, .eg_rd_in, .ack_in, .ack_qtype_in, .ack_len_in, .port_visible_out,
		.adv_data_credit_out, .adv_hdr_credit_out);
	xb_link_model lnk (.clk_in, .rst_in, .eg_valid_in(eg_valid_out), .eg_eop_in(eg_eop_out),
		.eg_qtype_in(eg_qtype_out), .hold_in(hold), .ack_en_in(ack_en), .eg_rd_out(eg_rd_in),
		.ack_out(ack_in), .ack_qtype_out(ack_qtype_in), .ack_len_out(ack_len_in));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [37:0] creds(logic m);
		if (m) return {xb_pkg::X8_HCRED, xb_pkg::X8_PC_DCRED, xb_pkg::X8_NP_DCRED, xb_pkg::X8_PC_DCRED};
		return {xb_pkg::X4_HCRED, xb_pkg::X4_PC_DCRED, xb_pkg::X4_NP_DCRED, xb_pkg::X4_PC_DCRED};
	endfunction
	function automatic int pending();
		int n = 0;
		foreach (expq[i]) n += expq[i].size();
		return n;
	endfunction
	task automatic chk(string what, logic [199:0] seen, logic [199:0] want);
		n_compared++;
		if (seen !== want) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(logic [5:0] m);
		rst_in = 1'b1;
		merge_in = m;
		repeat (6) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (2) @(negedge clk_in);
	endtask
	// One packet with its descriptor on the sop word; source holds while refused
	task automatic send(int p, int d, logic [1:0] q, int nw);
		logic [2:0] tc;
		logic [159:0] w;
		int k;
		tc = 3'(rnd());
		for (int i = 0; i < nw; i++) begin
			w = {4'(p), 28'(rnd()), rnd(), rnd(), rnd(), rnd()};
			ing_valid_in[p] = 1'b1;
			ing_sop_in[p] = (i == 0);
			ing_eop_in[p] = (i == nw - 1);
			ing_data_in[p] = w;
			ing_dest_in[p] = 4'(d);
			ing_qtype_in[p] = q;
			ing_tc_in[p] = tc;
			ing_len_in[p] = 14'(nw * 20);
			expq[p * 12 + d].push_back({q, tc_vc_map_in[d][tc], i == 0, i == nw - 1, w});
			for (k = 0; k < 2000 && ing_ready_out[p][q] !== 1'b1; k++) @(negedge clk_in);
			if (k == 2000) begin
				error_cnt++;
				conclude();
			end
			@(negedge clk_in);
		end
	endtask
	task automatic traffic(int p, int n, logic m);
		int d;
		for (int i = 0; i < n; i++) begin
			d = int'(rnd() % 12);
			if (m && d == 1) d = 0;
			send(p, d, 2'(rnd() % 3), int'(rnd() % 4) + 1);
		end
		ing_valid_in[p] = 1'b0;
		@(negedge clk_in);
	endtask
	task automatic drain();
		int k;
		for (k = 0; k < 3000 && pending() != 0; k++) @(negedge clk_in);
		chk("words left", 200'(pending()), 200'(0));
		if (k == 3000) conclude();
		repeat (60) @(negedge clk_in);
	endtask
	// Egress words in order per source and destination, with class mapped
	always @(posedge clk_in) begin
		for (int p = 0; p < 12; p++) begin
			if (!rst_in && eg_valid_out[p] && eg_rd_in[p]) begin
				idx = int'(eg_data_out[p][159:156]) * 12 + p;
				if (expq[idx].size() == 0) chk("stray word", 200'(p), 200'(99));
				else chk("egress word", 200'({eg_qtype_out[p], eg_vc_out[p], eg_sop_out[p],
					eg_eop_out[p], eg_data_out[p]}), 200'(expq[idx].pop_front()));
				deliv[p] += int'(eg_eop_out[p]);
			end
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int k, base;
		{rst_in, merge_in, ing_valid_in, ing_sop_in, ing_eop_in, ing_data_in} = '0;
		{ing_dest_in, ing_qtype_in, ing_tc_in, ing_len_in, hold} = '0;
		ack_en = 12'hfff;
		for (int p = 0; p < 12; p++) tc_vc_map_in[p] = 8'(rnd());
		do_reset(6'h00);
		for (int p = 0; p < 12; p++) begin
			chk("credits", 200'({adv_hdr_credit_out[p], adv_data_credit_out[p]}),
				200'(creds(1'b0)));
			chk("ready visible", 200'({ing_ready_out[p], port_visible_out[p]}),
				200'(4'hf));
		end
		// Queue code 3 names no queue: such a word must never be taken
		{ing_valid_in[3], ing_sop_in[3], ing_eop_in[3], ing_dest_in[3], ing_qtype_in[3]} =
			{3'h7, 4'h4, 2'h3};
		repeat (10) @(negedge clk_in);
		ing_valid_in[3] = 1'b0;
		chk("bad queue code", 200'(deliv[4]), 200'(0));
		$display("test reset values done");
		for (int p = 0; p < 12; p++) fork
			automatic int s = p;
			traffic(s, 6, 1'b0);
		join_none
		wait fork;
		drain();
		$display("test random traffic done");
		// A held egress port must not block later packets of the same source
		hold[5] = 1'b1;
		send(0, 5, 2'h0, 2);
		send(0, 6, 2'h2, 2);
		ing_valid_in[0] = 1'b0;
		for (k = 0; k < 500 && expq[6].size() != 0; k++) @(negedge clk_in);
		chk("words to free port", 200'(expq[6].size()), 200'(0));
		chk("words to held port", 200'(expq[5].size()), 200'(2));
		hold[5] = 1'b0;
		drain();
		$display("test head of line done");
		// No acks: the replay cap stops egress, then ingress refuses
		ack_en[0] = 1'b0;
		base = deliv[0];
		// Every packet goes to port 0; posted and completion only, so byte limits stay far off
		fork
			begin
				logic [1:0] q;
				for (int i = 0; i < 60; i++) begin
					q = rnd() % 2 == 0 ? xb_pkg::Q_POSTED : xb_pkg::Q_COMPLETION;
					send(2, 0, q, int'(rnd() % 4) + 1);
				end
				ing_valid_in[2] = 1'b0;
			end
		join_none
		repeat (1500) @(negedge clk_in);
		chk("packets under cap", 200'(deliv[0] - base), 200'(xb_pkg::X4_REPLAY));
		chk("full ready", 200'(ing_ready_out[2]), 200'(0));
		ack_en[0] = 1'b1;
		wait fork;
		drain();
		chk("packets after acks", 200'(deliv[0] - base), 200'(60));
		$display("test replay cap done");
		do_reset(6'h01);
		chk("odd port", 200'({port_visible_out[1], ing_ready_out[1]}), 200'(0));
		chk("x8 credits", 200'({adv_hdr_credit_out[0], adv_data_credit_out[0]}),
			200'(creds(1'b1)));
		for (int p = 0; p < 12; p++) if (p != 1) fork
			automatic int s = p;
			traffic(s, 4, 1'b1);
		join_none
		wait fork;
		drain();
		$display("test merged mode done");
		conclude();
	end
endmodule

// ===== tb/xb_link_model.sv
/*
 Link layer model for the egress side of every port.
 Assumes the bench steers stalls and acks through hold_in and ack_en_in.
*/
`timescale 1ns/1ps
module xb_link_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [11:0] eg_valid_in,
	input wire logic [11:0] eg_eop_in,
	input wire logic [11:0][1:0] eg_qtype_in,
	input wire logic [11:0] hold_in,
	input wire logic [11:0] ack_en_in,
	output logic [11:0] eg_rd_out,
	output logic [11:0] ack_out,
	output logic [11:0][1:0] ack_qtype_out,
	output logic [11:0][13:0] ack_len_out
);
	logic [15:0] pend [12][$];
	int words [12];
	int cyc;
	initial begin
		{eg_rd_out, ack_out, ack_qtype_out, ack_len_out} = '0;
		cyc = 0;
	end
	// Count the words of each packet read; a finished one waits for its ack
	always @(posedge clk_in) begin
		for (int p = 0; p < 12; p++) begin
			if (rst_in) begin
				pend[p].delete();
				words[p] = 0;
			end else if (eg_valid_in[p] && eg_rd_out[p]) begin
				words[p]++;
				if (eg_eop_in[p]) begin
					pend[p].push_back({eg_qtype_in[p], 14'(words[p] * 20)});
					words[p] = 0;
				end
			end
		end
	end
	// Reads skip every third cycle so the core sees a slow reader too
	always @(negedge clk_in) begin
		cyc++;
		for (int p = 0; p < 12; p++) begin
			eg_rd_out[p] <= !rst_in && !hold_in[p] && ((cyc + p) % 3 != 0);
			if (!rst_in && ack_en_in[p] && pend[p].size() != 0 && (cyc + p) % 2 == 0) begin
				{ack_qtype_out[p], ack_len_out[p]} <= pend[p].pop_front();
				ack_out[p] <= 1'b1;
			end else begin
				ack_out[p] <= 1'b0;
				ack_len_out[p] <= ~ack_len_out[p];
			end
		end
	end
endmodule
